// ---- logic/lpf_top.sv ----
// lpf_top: duty store for current sinks 15 to 17 with frame-synchronised refresh
// assumes the register port is driven synchronously to REF_CLK_IN;
// the frame-sync pin is asynchronous and is synchronised here
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - refresh mode one loads new duty data into outputs immediately.
// - frame-sync rates of 60, 90, 120 Hz and above are supported.
// - sink 16 duty low byte at 220h, high byte at 221h.
// - sink 17 duty low byte at 222h, high byte at 223h.
// - sink 15 high duty byte is a full readable writable byte.
// - every duty byte is read/write and resets to zero.
module lpf_top (
  input  wire logic        REF_CLK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic [9:0]  REG_ADDR_IN,
  input  wire logic [7:0]  REG_WDATA_IN,
  input  wire logic        REG_WRITE_IN,
  input  wire logic        REG_READ_IN,
  input  wire logic [1:0]  REFRESH_MODE_IN,
  input  wire logic        FRAME_SYNC_IN,
  output logic      [7:0]  REG_RDATA_OUT,
  output logic             REG_RVALID_OUT,
  output logic      [2:0]  SINK_PWM_OUT
);

  lpf_pkg::lpf_top_state_s state_reg;
  lpf_pkg::lpf_top_state_s state_next;

  logic [9:0]  rel_addr;
  logic        addr_hit;
  logic [2:0]  byte_idx;
  logic        sync_rise;
  logic        sync_mode;
  logic [15:0] duty_word [3];

  ////////////////////////////////////////////////////////////////////////////////
  // address decode over the contiguous six-byte window

  assign rel_addr = REG_ADDR_IN - lpf_pkg::STORE_BASE_OFS;
  assign addr_hit = (REG_ADDR_IN >= lpf_pkg::SINK15_DUTY_LOW_OFS) &&
                    (REG_ADDR_IN <= lpf_pkg::SINK17_DUTY_HIGH_OFS);
  assign byte_idx = rel_addr[2:0];

  // only the synchronised edge is used; the meta flop feeds nothing else
  assign sync_rise = state_reg.sync_stable && !state_reg.sync_prev;
  assign sync_mode = (REFRESH_MODE_IN == lpf_pkg::LPF_MODE_TWO) ||
                     (REFRESH_MODE_IN == lpf_pkg::LPF_MODE_THREE);

  ////////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    state_next             = state_reg;
    state_next.sync_meta   = FRAME_SYNC_IN;
    state_next.sync_stable = state_reg.sync_meta;
    state_next.sync_prev   = state_reg.sync_stable;
    state_next.rvalid      = 1'b0;

    // writes land in the store directly; rule-abiding hosts never write during
    // the frame-sync high pulse, so no write blocking is done here
    if (REG_WRITE_IN && addr_hit) begin
      state_next.duty_bytes[byte_idx] = REG_WDATA_IN;
    end

    if (REG_READ_IN) begin
      state_next.rvalid = 1'b1;
      state_next.rdata  = addr_hit ? state_reg.duty_bytes[byte_idx] : 8'h00;
    end

    // free-running period counter restarts at each frame in modes two and three, so every such frame opens
    // on a fresh pwm period; a 16-bit period at 200 MHz is about 328 us, well
    // inside a 120 Hz frame
    if (sync_mode && sync_rise) begin
      state_next.count = lpf_pkg::COUNT_RESET;
    end else begin
      state_next.count = state_reg.count + 16'h0001;
    end

    if (sync_mode) begin
      state_next.load = sync_rise;
    end else begin
      state_next.load = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      state_reg.duty_bytes  <= '{default: lpf_pkg::DUTY_BYTE_RESET};
      state_reg.rdata       <= 8'h00;
      state_reg.rvalid      <= 1'b0;
      state_reg.sync_meta   <= 1'b0;
      state_reg.sync_stable <= 1'b0;
      state_reg.sync_prev   <= 1'b0;
      state_reg.load        <= 1'b0;
      state_reg.count       <= lpf_pkg::COUNT_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // duty words and pwm channels

  generate
    for (genvar i = 0; i < 3; i++) begin : g_sink
      // low byte at the even offset, high byte at the odd one
      assign duty_word[i] = {state_reg.duty_bytes[2*i+1], state_reg.duty_bytes[2*i]};

      lpf_pwm_channel u_chan (
        .clk_in     (REF_CLK_IN),
        .reset_n_in (RESET_N_IN),
        .load_in    (state_reg.load),
        .duty_in    (duty_word[i]),
        .count_in   (state_reg.count),
        .pwm_out    (SINK_PWM_OUT[i])
      );
    end
  endgenerate

  assign REG_RDATA_OUT  = state_reg.rdata;
  assign REG_RVALID_OUT = state_reg.rvalid;

endmodule : lpf_top

// ---- logic/lpf_pkg.sv ----
// lpf_pkg: constants and types for the frame-synchronised pwm brightness store
// assumes a single 200 MHz clock domain and a byte-wide register port
package lpf_pkg;

  localparam int unsigned ADDR_W        = 10;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned DUTY_W        = 16;
  localparam int unsigned NUM_SINKS     = 3;
  localparam int unsigned NUM_BYTES     = 6;

  // byte offsets of the duty store, low byte then high byte per sink
  localparam logic [9:0] SINK15_DUTY_LOW_OFS  = 10'h21E;
  localparam logic [9:0] SINK15_DUTY_HIGH_OFS = 10'h21F;
  localparam logic [9:0] SINK16_DUTY_LOW_OFS  = 10'h220;
  localparam logic [9:0] SINK16_DUTY_HIGH_OFS = 10'h221;
  localparam logic [9:0] SINK17_DUTY_LOW_OFS  = 10'h222;
  localparam logic [9:0] SINK17_DUTY_HIGH_OFS = 10'h223;
  localparam logic [9:0] STORE_BASE_OFS       = SINK15_DUTY_LOW_OFS;

  localparam logic [7:0]  DUTY_BYTE_RESET = 8'h00;
  localparam logic [15:0] DUTY_RESET      = 16'h0000;
  localparam logic [15:0] COUNT_RESET     = 16'h0000;

  // refresh modes; zero is treated as instant refresh
  typedef enum logic [1:0] {
    LPF_MODE_NONE   = 2'h0,
    LPF_MODE_ONE    = 2'h1,
    LPF_MODE_TWO    = 2'h2,
    LPF_MODE_THREE  = 2'h3
  } lpf_mode_e;

  // frame-sync minimum high time and repetition rates the scheme supports
  localparam int unsigned CLK_HZ                  = 200_000_000;
  localparam int unsigned FRAME_SYNC_MIN_HIGH_NS  = 1000;
  localparam int unsigned FRAME_SYNC_MIN_HIGH_CYC =
    (FRAME_SYNC_MIN_HIGH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned FRAME_RATE_LOW_HZ       = 60;
  localparam int unsigned FRAME_RATE_MID_HZ       = 90;
  localparam int unsigned FRAME_RATE_HIGH_HZ      = 120;

  typedef struct packed {
    logic [NUM_BYTES-1:0][DATA_W-1:0] duty_bytes;
    logic [DATA_W-1:0]                rdata;
    logic                             rvalid;
    logic                             sync_meta;
    logic                             sync_stable;
    logic                             sync_prev;
    logic                             load;
    logic [DUTY_W-1:0]                count;
  } lpf_top_state_s;

  typedef struct packed {
    logic [DUTY_W-1:0] duty_active;
    logic              pwm;
  } lpf_chan_state_s;

endpackage : lpf_pkg

// ---- logic/lpf_pwm_channel.sv ----
// lpf_pwm_channel: one current sink's active duty latch and pwm comparator
// assumes the shared period counter and load strobe come from the same clock
`timescale 1ns/1ps

module lpf_pwm_channel (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        load_in,
  input  wire logic [15:0] duty_in,
  input  wire logic [15:0] count_in,
  output logic             pwm_out
);

  lpf_pkg::lpf_chan_state_s state_reg;
  lpf_pkg::lpf_chan_state_s state_next;

  always_comb begin
    state_next = state_reg;
    if (load_in) begin
      state_next.duty_active = duty_in;
    end
    // output high while the counter is below the active duty
    state_next.pwm = (count_in < state_reg.duty_active);
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_reg.duty_active <= lpf_pkg::DUTY_RESET;
      state_reg.pwm         <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pwm_out = state_reg.pwm;

endmodule : lpf_pwm_channel

// ---- verification/lpf_host_model.sv ----
// lpf_host_model: host side that raises the frame-sync pin on request
// assumes fire_in rises once per wanted frame; pin edges follow a 125 ns link clock
`timescale 1ns/1ps
module lpf_host_model (
  input  wire logic fire_in,
  output logic      frame_sync_out
);
  logic link_clk = 1'b0;
  initial frame_sync_out = 1'b0;
  // offset keeps pin edges off the core clock edges
  initial begin
    #1.3;
    forever #62.5 link_clk = ~link_clk;
  end
  // ten link periods high, well above the minimum high width
  always @(posedge fire_in) begin
    @(posedge link_clk) frame_sync_out = 1'b1;
    repeat (10) @(posedge link_clk);
    frame_sync_out = 1'b0;
  end
endmodule : lpf_host_model

// ---- verification/lpf_top_assertions.sv ----
// lpf_top_assertions: port checks of the duty store and refresh timing
// assumes binding to lpf_top; sees only its ports
`timescale 1ns/1ps
module lpf_top_assertions (
  input wire logic       REF_CLK_IN,
  input wire logic       RESET_N_IN,
  input wire logic [9:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic       REG_WRITE_IN,
  input wire logic       REG_READ_IN,
  input wire logic [1:0] REFRESH_MODE_IN,
  input wire logic       FRAME_SYNC_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire logic       REG_RVALID_OUT,
  input wire logic [2:0] SINK_PWM_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  logic        sync_reg;
  logic [15:0] since_reg;
  // saturates, so only a sync seen in a synchronised mode arms the frame check
  always_ff @(posedge REF_CLK_IN) begin
    sync_reg <= FRAME_SYNC_IN;
    if (!RESET_N_IN || !REFRESH_MODE_IN[1]) since_reg <= 16'hFFFF;
    else if (FRAME_SYNC_IN && !sync_reg) since_reg <= 16'h0000;
    else if (since_reg != 16'hFFFF) since_reg <= since_reg + 16'h0001;
  end
  chk_read_answer: assert property (REG_READ_IN |=> REG_RVALID_OUT)
    else $error("read unanswered");
  chk_no_stray: assert property (!REG_READ_IN |=> !REG_RVALID_OUT)
    else $error("stray rvalid");
  chk_rdata_hold: assert property (!REG_RVALID_OUT |-> $stable(REG_RDATA_OUT))
    else $error("rdata moved");
  chk_unmapped_zero: assert property (
    REG_READ_IN && !(REG_ADDR_IN inside {[10'h21E:10'h223]}) |=> REG_RDATA_OUT == 8'h00)
    else $error("unmapped read not zero");
  chk_write_readback: assert property (
    REG_WRITE_IN && REG_ADDR_IN inside {[10'h21E:10'h223]} ##1 !REG_WRITE_IN ##1
    REG_READ_IN && !REG_WRITE_IN && REG_ADDR_IN == $past(REG_ADDR_IN, 2)
    |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 3)) else $error("readback differs");
  chk_reset_dark: assert property ($rose(RESET_N_IN) |-> SINK_PWM_OUT == 3'h0)
    else $error("pwm lit after reset");
  chk_frame_steady: assert property (
    REFRESH_MODE_IN[1] && since_reg > 16'h0008 && since_reg < 16'hEA60
    |-> (SINK_PWM_OUT & ~$past(SINK_PWM_OUT)) == 3'h0) else $error("pwm rose mid-frame");
  chk_instant_off: assert property (
    REFRESH_MODE_IN == 2'h1 && REG_WRITE_IN && REG_ADDR_IN == 10'h222 &&
    REG_WDATA_IN == 8'h00 ##2 REG_WRITE_IN && REG_ADDR_IN == 10'h223 &&
    REG_WDATA_IN == 8'h00 && REFRESH_MODE_IN == 2'h1 |-> ##3 !SINK_PWM_OUT[2])
    else $error("mode one update late");
endmodule : lpf_top_assertions
bind lpf_top lpf_top_assertions chk (.*);

// ---- verification/test_lpf_top.sv ----
// test_lpf_top: self-checking bench for the duty store and frame refresh
// assumes lpf_top, its bound checker and lpf_host_model are compiled
`timescale 1ns/1ps
module test_lpf_top;
  typedef struct {logic [9:0] a; logic [7:0] d; logic [7:0] e;} lpf_row_s;
  logic       clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, fire = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [7:0] wdata = 8'h00, rdata;
  logic [1:0] mode = 2'h2;
  logic       fsync, rvalid;
  logic [2:0] pwm;
  int         n_fail = 0, checked = 0, cyc = 0;
  // last row is unmapped: its write is dropped and it reads zero
  lpf_row_s rows[7] = '{'{10'h21E, 8'h5A, 8'h5A}, '{10'h21F, 8'hA5, 8'hA5},
    '{10'h220, 8'h40, 8'h40}, '{10'h221, 8'h00, 8'h00}, '{10'h222, 8'h00, 8'h00},
    '{10'h223, 8'h01, 8'h01}, '{10'h224, 8'h77, 8'h00}};
  always #2.5 clk = ~clk;
  lpf_top dut (.REF_CLK_IN(clk), .RESET_N_IN(rst_n), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WRITE_IN(wr_en), .REG_READ_IN(rd_en),
    .REFRESH_MODE_IN(mode), .FRAME_SYNC_IN(fsync), .REG_RDATA_OUT(rdata),
    .REG_RVALID_OUT(rvalid), .SINK_PWM_OUT(pwm));
  lpf_host_model host (.fire_in(fire), .frame_sync_out(fsync));
  ////////////////////////////////////////////////////////////
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp
  // pwm seen after n cycles; returns on an edge so callers may drive at once
  task automatic see(input int n, input logic [2:0] e);
    repeat (n) @(posedge clk);
    #1 cmp({5'h00, pwm}, {5'h00, e});
    @(posedge clk);
  endtask : see
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a; rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    // rvalid stands for the single cycle after the sampling edge, so look now
    #1 cmp({7'h00, rvalid}, 8'h01);
    cmp(rdata, e);
  endtask : rd
  task automatic end_sim;
    $display("compares %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      n_fail++;
      end_sim;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) rd(rows[i].a, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    $display("register test done");
    see(0, 3'b000);
    fire <= 1'b1;
    see(30, 3'b111);
    see(70, 3'b101);
    see(200, 3'b001);
    wr(10'h221, 8'hFF);
    see(10, 3'b001);
    mode <= 2'h1;
    see(5, 3'b011);
    wr(10'h222, 8'h00);
    wr(10'h223, 8'h00);
    see(4, 3'b011);
    mode <= 2'h3;
    wr(10'h221, 8'h00);
    see(10, 3'b011);
    $display("refresh test done");
    repeat (65600) @(posedge clk);
    fire <= 1'b0;
    @(posedge clk);
    fire <= 1'b1;
    see(100, 3'b001);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(10'h21F, 8'h00);
    see(0, 3'b000);
    $display("reset test done");
    end_sim;
  end
endmodule : test_lpf_top
